// ---- pkg/sff_pkg.sv ----
package sff_pkg;
	// Array shape
	localparam int ADDR_W = 19;
	localparam int SECT_W = 3;
	localparam int DATA_W = 8;
	localparam int KIND_W = 2;
	localparam int BUF_W = KIND_W + ADDR_W + DATA_W;
	localparam int SECTORS = 8;
	localparam int PAGES_PER_SECTOR = 256;
	localparam int PAGE_BYTES = 256;
	localparam int SYNC_W = 5;
	// Opcodes, values arbitrary
	localparam logic [7:0] PAGE_WRITE_CMD = 8'hA1;
	localparam logic [7:0] SECTOR_WIPE_CMD = 8'hA2;
	localparam logic [7:0] CHIP_WIPE_CMD = 8'hA3;
	localparam logic [7:0] SLEEP_CMD = 8'hA4;
	localparam logic [7:0] WAKE_CMD = 8'hA5;
	localparam logic [7:0] READ_CMD = 8'hA6;
	localparam logic [7:0] STAT_CMD = 8'hA7;
	// Signature byte, value arbitrary
	localparam logic [7:0] SIG_BYTE = 8'h5A;
	// APB byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_GUARD = 8'h08;
	localparam logic [7:0] OFS_TX = 8'h0C;
	localparam logic [7:0] OFS_RX = 8'h10;
	// Status field positions
	localparam int ST_SEL = 0;
	localparam int ST_PAUSE = 1;
	localparam int ST_SLEEP = 2;
	localparam int ST_ARMED = 3;
	localparam int ST_STANDBY = 4;
	localparam int ST_OVR = 5;
	localparam int ST_REF = 6;
	localparam int ST_BUF_W = 27;
	localparam int RX_VALID = 31;
	localparam logic [2:0] GUARD_RST = 3'h0;
	localparam logic [7:0] TX_RST = 8'hFF;
	// Entry kinds in the buffer
	typedef enum logic [1:0] {KIND_DATA, KIND_PAGE, KIND_SECTOR, KIND_CHIP} sff_kind_t;
	// Serial state, Gray along the usual path
	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_OPC = 3'h1, S_ADDR = 3'h3, S_DATA = 3'h2, S_OUT = 3'h6, S_SKIP = 3'h7
	} sff_state_t;
endpackage

// ---- pkg/sff_stream_if.sv ----
`timescale 1ns/1ns
interface sff_stream_if;
	logic valid; // Word offered
	logic ready; // Word taken
	logic [sff_pkg::BUF_W-1:0] data; // {kind, address, byte}
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// ---- rtl/sff_sync.sv ----
`timescale 1ns/1ns
module sff_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	// Two stages per pin; first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_ff;
			logic s2_ff;
			always_ff @(posedge clk_sys_in) begin
				if (reset_in) begin
					s1_ff <= RST_VAL[i];
					s2_ff <= RST_VAL[i];
				end else if (ce_in) begin
					s1_ff <= d_in[i];
					s2_ff <= s1_ff;
				end
			end
			assign q_out[i] = s2_ff;
		end
	endgenerate
endmodule

// ---- rtl/sff_buf.sv ----
`timescale 1ns/1ns
module sff_buf #(
	parameter int W = sff_pkg::BUF_W,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic ce_in,
	sff_stream_if.snk in_s,
	sff_stream_if.src out_s
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH]; // Storage
	logic [PW-1:0] wp_ff; // Write slot
	logic [PW-1:0] rp_ff; // Read slot
	logic [PW:0] cnt_ff; // Fill level
	logic push;
	logic pop;
	// Honest full and empty
	assign in_s.ready = (cnt_ff != (PW+1)'(DEPTH));
	assign out_s.valid = (cnt_ff != '0);
	assign out_s.data = mem[rp_ff];
	assign push = in_s.valid & in_s.ready & ce_in;
	assign pop = out_s.valid & out_s.ready & ce_in;
	// Slot write
	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			mem[wp_ff] <= in_s.data;
		end
	end
	// Pointers and level
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wp_ff <= (wp_ff == PW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
			end
			if (pop) begin
				rp_ff <= (rp_ff == PW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
			end
			if (push & ~pop) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else if (pop & ~push) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end
endmodule

// ---- rtl/sff_front.sv ----
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Operation
// - Output bit changes after clock falling edge
// - Input bit sampled on clock rising edge
// - Opcode, address, data all on input line
// - Deselected means output high impedance
// - Deselected idle enters standby, busy stays active
// - Select low means selected and active
// - No instruction before first select falling edge
// - Pause suspends exchange, resumes where stopped
// - Paused: output off, clock and data ignored
// - Pause only starts while selected
// - Write-protect low freezes area guard bits
// - Eight sectors of 256 pages, 256 bytes
// - Page write takes 1 to 256 bytes
// - Sector wipe or whole chip wipe
// - Clock idles low or high, same edges
// - Asleep: only wake command accepted
// - Pause never aborts internal cycle
module sff_front (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic sclk_in,
	input wire logic sel_n_in,
	input wire logic mosi_in,
	input wire logic pause_n_in,
	input wire logic wp_n_in,
	output logic miso_out,
	output logic miso_oe_out,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out
);
	logic [sff_pkg::SYNC_W-1:0] pins; // Synchronised pins
	logic s_sclk;
	logic s_sel_n;
	logic s_mosi;
	logic s_pause_n;
	logic s_wp_n;
	logic sclk_q_ff; // Last clock level
	logic sel_q_ff; // Last select level
	logic armed_ff; // Select edge seen
	logic paused_ff; // Pause active
	logic sleep_ff; // Deep power-down
	logic busy_ff; // Internal cycle running
	logic standby_ff; // Standby power mode
	logic [2:0] guard_ff; // Area guard bits
	logic [7:0] tx_ff; // Byte to send
	logic [7:0] rx_sh_ff; // Input shifter
	logic [2:0] bit_ff; // Bit in byte
	logic [1:0] abyte_ff; // Address byte count
	logic [8:0] pcnt_ff; // Page bytes taken
	logic [sff_pkg::ADDR_W-1:0] addr_ff; // Byte address
	logic [7:0] opc_ff; // Current opcode
	logic wipe_ff; // Wipe pending at deselect
	logic [7:0] tx_sh_ff; // Output shifter
	logic ovr_ff; // Word lost flag
	logic ref_ff; // Refused by guard flag
	logic stg_v_ff; // Staged word valid
	logic [sff_pkg::BUF_W-1:0] stg_ff; // Staged word
	logic miso_ff;
	logic oe_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	sff_pkg::sff_state_t st_ff;
	sff_pkg::sff_state_t nxt_st;
	logic rise;
	logic fall;
	logic sel_fall;
	logic sel_rise;
	logic act;
	logic byte_done;
	logic [7:0] byte_val;
	logic push;
	logic [sff_pkg::BUF_W-1:0] push_word;
	logic acc;
	logic wr;
	sff_stream_if in_s ();
	sff_stream_if out_s ();

	// Guard bits to protected sectors
	function automatic logic guarded(input logic [2:0] g, input logic [sff_pkg::SECT_W-1:0] sec);
		logic r;
		r = 1'b0;
		unique case (g)
			3'h0: r = 1'b0;
			3'h1: r = (sec == 3'h7);
			3'h2: r = (sec >= 3'h6);
			3'h3: r = (sec >= 3'h4);
			default: r = 1'b1;
		endcase
		return r;
	endfunction

	// Register decode, used for the error flag only
	function automatic logic mapped(input logic [7:0] a);
		return (a == sff_pkg::OFS_CTRL) || (a == sff_pkg::OFS_STAT) || (a == sff_pkg::OFS_GUARD) ||
			(a == sff_pkg::OFS_TX) || (a == sff_pkg::OFS_RX);
	endfunction

	// Pins cross over; select resets low, so one already low at release shows no edge
	sff_sync #(.W(sff_pkg::SYNC_W), .RST_VAL(5'h03)) u_sync (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.ce_in(ce_in),
		.d_in({sclk_in, sel_n_in, mosi_in, pause_n_in, wp_n_in}),
		.q_out(pins)
	);
	assign {s_sclk, s_sel_n, s_mosi, s_pause_n, s_wp_n} = pins;

	// Edge finding on the sampled serial clock; either idle level works
	assign rise = s_sclk & ~sclk_q_ff;
	assign fall = ~s_sclk & sclk_q_ff;
	assign sel_fall = sel_q_ff & ~s_sel_n;
	assign sel_rise = ~sel_q_ff & s_sel_n;
	assign act = ~s_sel_n & armed_ff & ~paused_ff;
	assign byte_done = act & rise & (bit_ff == 3'h7);
	assign byte_val = {rx_sh_ff[6:0], s_mosi};

	// Previous levels
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			sclk_q_ff <= 1'b0;
			sel_q_ff <= 1'b0;
		end else if (ce_in) begin
			sclk_q_ff <= s_sclk;
			sel_q_ff <= s_sel_n;
		end
	end

	// First select edge after reset arms the port
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			armed_ff <= 1'b0;
		end else if (ce_in && sel_fall) begin
			armed_ff <= 1'b1;
		end
	end

	// Pause tracking; a deselect ends it
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			paused_ff <= 1'b0;
		end else if (ce_in) begin
			if (s_sel_n) begin
				paused_ff <= 1'b0;
			end else if (!s_pause_n) begin
				paused_ff <= 1'b1;
			end else begin
				paused_ff <= 1'b0;
			end
		end
	end

	// Power mode; busy is untouched by pause or deselect
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			standby_ff <= 1'b1;
		end else if (ce_in) begin
			standby_ff <= s_sel_n & ~busy_ff;
		end
	end

	// Input shifter and bit count; frozen while paused
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			rx_sh_ff <= 8'h00;
			bit_ff <= 3'h0;
		end else if (ce_in) begin
			if (s_sel_n) begin
				bit_ff <= 3'h0;
			end else if (act && rise) begin
				rx_sh_ff <= byte_val;
				bit_ff <= bit_ff + 3'h1;
			end
		end
	end

	// Command sequencer next state
	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			sff_pkg::S_IDLE: nxt_st = sel_fall ? sff_pkg::S_OPC : sff_pkg::S_IDLE;
			sff_pkg::S_OPC: begin
				if (byte_done) begin
					if (sleep_ff) begin
						nxt_st = (byte_val == sff_pkg::WAKE_CMD) ? sff_pkg::S_OUT : sff_pkg::S_SKIP;
					end else if (byte_val == sff_pkg::PAGE_WRITE_CMD || byte_val == sff_pkg::SECTOR_WIPE_CMD ||
						byte_val == sff_pkg::READ_CMD) begin
						nxt_st = sff_pkg::S_ADDR;
					end else if (byte_val == sff_pkg::STAT_CMD || byte_val == sff_pkg::WAKE_CMD) begin
						nxt_st = sff_pkg::S_OUT;
					end else begin
						nxt_st = sff_pkg::S_SKIP;
					end
				end
			end
			sff_pkg::S_ADDR: begin
				if (byte_done && abyte_ff == 2'h2) begin
					if (opc_ff == sff_pkg::PAGE_WRITE_CMD) begin
						nxt_st = sff_pkg::S_DATA;
					end else if (opc_ff == sff_pkg::READ_CMD) begin
						nxt_st = sff_pkg::S_OUT;
					end else begin
						nxt_st = sff_pkg::S_SKIP;
					end
				end
			end
			sff_pkg::S_DATA: nxt_st = sff_pkg::S_DATA;
			sff_pkg::S_OUT: nxt_st = sff_pkg::S_OUT;
			sff_pkg::S_SKIP: nxt_st = sff_pkg::S_SKIP;
			default: nxt_st = sff_pkg::S_IDLE;
		endcase
		if (s_sel_n) begin
			nxt_st = sff_pkg::S_IDLE;
		end
	end

	// State register; unarmed select never leaves idle
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			st_ff <= sff_pkg::S_IDLE;
		end else if (ce_in) begin
			st_ff <= nxt_st;
		end
	end

	// Opcode, address and page byte count
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			opc_ff <= 8'h00;
			abyte_ff <= 2'h0;
			addr_ff <= '0;
			pcnt_ff <= 9'h000;
		end else if (ce_in && byte_done) begin
			if (st_ff == sff_pkg::S_OPC) begin
				opc_ff <= byte_val;
				abyte_ff <= 2'h0;
				pcnt_ff <= 9'h000;
			end else if (st_ff == sff_pkg::S_ADDR) begin
				addr_ff <= {addr_ff[sff_pkg::ADDR_W-9:0], byte_val};
				abyte_ff <= abyte_ff + 2'h1;
			end else if (st_ff == sff_pkg::S_DATA && pcnt_ff != 9'(sff_pkg::PAGE_BYTES)) begin
				addr_ff[7:0] <= addr_ff[7:0] + 8'h01;
				pcnt_ff <= pcnt_ff + 9'h001;
			end
		end
	end

	// Sleep entry and wake; wipe request held until deselect
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			sleep_ff <= 1'b0;
			wipe_ff <= 1'b0;
		end else if (ce_in) begin
			if (byte_done && st_ff == sff_pkg::S_OPC) begin
				if (sleep_ff) begin
					sleep_ff <= (byte_val != sff_pkg::WAKE_CMD);
				end else begin
					sleep_ff <= (byte_val == sff_pkg::SLEEP_CMD);
					wipe_ff <= (byte_val == sff_pkg::CHIP_WIPE_CMD);
				end
			end else if (byte_done && st_ff == sff_pkg::S_ADDR && abyte_ff == 2'h2) begin
				wipe_ff <= (opc_ff == sff_pkg::SECTOR_WIPE_CMD);
			end else if (byte_done || sel_rise) begin
				wipe_ff <= 1'b0; // Extra bits void the wipe
			end
		end
	end

	// Words for the buffer: page bytes live, wipes at deselect on a byte boundary
	always_comb begin
		push = 1'b0;
		push_word = '0;
		if (byte_done && st_ff == sff_pkg::S_DATA && pcnt_ff != 9'(sff_pkg::PAGE_BYTES) &&
			!guarded(guard_ff, addr_ff[sff_pkg::ADDR_W-1 -: sff_pkg::SECT_W])) begin
			push = 1'b1;
			push_word = {sff_pkg::KIND_DATA, addr_ff, byte_val};
		end else if (sel_rise && wipe_ff && bit_ff == 3'h0) begin
			push = (opc_ff == sff_pkg::CHIP_WIPE_CMD) ? (guard_ff == 3'h0) :
				!guarded(guard_ff, addr_ff[sff_pkg::ADDR_W-1 -: sff_pkg::SECT_W]);
			push_word = {(opc_ff == sff_pkg::CHIP_WIPE_CMD) ? sff_pkg::KIND_CHIP : sff_pkg::KIND_SECTOR,
				addr_ff, 8'h00};
		end
	end

	// Staging register waits out a stalled buffer
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			stg_v_ff <= 1'b0;
			stg_ff <= '0;
		end else if (ce_in) begin
			if (push && !(stg_v_ff && !in_s.ready)) begin
				stg_v_ff <= 1'b1;
				stg_ff <= push_word;
			end else if (in_s.ready) begin
				stg_v_ff <= 1'b0;
			end
		end
	end
	assign in_s.valid = stg_v_ff;
	assign in_s.data = stg_ff;

	// Two-entry buffer towards software
	sff_buf #(.W(sff_pkg::BUF_W), .DEPTH(2)) u_buf (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.ce_in(ce_in),
		.in_s(in_s),
		.out_s(out_s)
	);

	// Output shifter: load at byte boundary, shift on falling edge
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			tx_sh_ff <= 8'hFF;
			miso_ff <= 1'b0;
		end else if (ce_in) begin
			if (byte_done && nxt_st == sff_pkg::S_OUT) begin
				if (st_ff == sff_pkg::S_OPC && byte_val == sff_pkg::STAT_CMD) begin
					tx_sh_ff <= {3'h0, guard_ff, s_wp_n, busy_ff};
				end else if (st_ff == sff_pkg::S_OPC || opc_ff == sff_pkg::WAKE_CMD) begin
					tx_sh_ff <= sff_pkg::SIG_BYTE;
				end else if (opc_ff == sff_pkg::STAT_CMD) begin
					tx_sh_ff <= {3'h0, guard_ff, s_wp_n, busy_ff};
				end else begin
					tx_sh_ff <= tx_ff;
				end
			end else if (act && fall && st_ff == sff_pkg::S_OUT) begin
				miso_ff <= tx_sh_ff[7];
				tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
			end
		end
	end

	// Drive only while selected, armed, unpaused and sending
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			oe_ff <= 1'b0;
		end else if (ce_in) begin
			oe_ff <= act & (st_ff == sff_pkg::S_OUT);
		end
	end
	assign miso_out = miso_ff;
	assign miso_oe_out = oe_ff;

	// APB: one wait cycle so read data comes from a flop
	assign acc = psel_in & penable_in & pready_ff;
	assign wr = acc & pwrite_in & ~pslverr_ff;
	assign out_s.ready = acc & ~pwrite_in & (paddr_in == sff_pkg::OFS_RX);

	// Ready, error and read data
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else if (ce_in) begin
			pready_ff <= psel_in & penable_in & ~pready_ff;
			pslverr_ff <= psel_in & penable_in & ~pready_ff & ~mapped(paddr_in);
			prdata_ff <= 32'h0000_0000;
			if (psel_in && penable_in && !pready_ff && !pwrite_in) begin
				unique case (paddr_in)
					sff_pkg::OFS_CTRL: prdata_ff <= {31'h0, busy_ff};
					sff_pkg::OFS_STAT: prdata_ff <= {4'h0, out_s.valid, 19'h0, 1'b0, ref_ff, ovr_ff,
						standby_ff, armed_ff, sleep_ff, paused_ff, ~s_sel_n};
					sff_pkg::OFS_GUARD: prdata_ff <= {29'h0, guard_ff};
					sff_pkg::OFS_TX: prdata_ff <= {24'h0, tx_ff};
					sff_pkg::OFS_RX: prdata_ff <= {out_s.valid, 2'h0, out_s.data};
					default: prdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end
	assign prdata_out = prdata_ff;
	assign pready_out = pready_ff;
	assign pslverr_out = pslverr_ff;

	// Software-owned control
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			busy_ff <= 1'b0;
			tx_ff <= sff_pkg::TX_RST;
		end else if (ce_in && wr) begin
			if (paddr_in == sff_pkg::OFS_CTRL) begin
				busy_ff <= pwdata_in[0];
			end
			if (paddr_in == sff_pkg::OFS_TX) begin
				tx_ff <= pwdata_in[7:0];
			end
		end
	end

	// Guard bits frozen while write-protect is low
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			guard_ff <= sff_pkg::GUARD_RST;
		end else if (ce_in && wr && paddr_in == sff_pkg::OFS_GUARD && s_wp_n) begin
			guard_ff <= pwdata_in[2:0];
		end
	end

	// Sticky flags, write one to clear; a new event beats the clear
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			ovr_ff <= 1'b0;
			ref_ff <= 1'b0;
		end else if (ce_in) begin
			if (push && stg_v_ff && !in_s.ready) begin
				ovr_ff <= 1'b1;
			end else if (wr && paddr_in == sff_pkg::OFS_STAT && pwdata_in[sff_pkg::ST_OVR]) begin
				ovr_ff <= 1'b0;
			end
			if ((byte_done && st_ff == sff_pkg::S_DATA && pcnt_ff != 9'(sff_pkg::PAGE_BYTES) && !push) ||
				(sel_rise && wipe_ff && bit_ff == 3'h0 && !push)) begin
				ref_ff <= 1'b1;
			end else if (wr && paddr_in == sff_pkg::OFS_STAT && pwdata_in[sff_pkg::ST_REF]) begin
				ref_ff <= 1'b0;
			end
		end
	end
endmodule

// ---- verification/sff_front_monitor.sv ----
`timescale 1ns/1ns
// Pin and register bus checker for the serial front end
module sff_front_monitor (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic sclk_in,
	input wire logic sel_n_in,
	input wire logic pause_n_in,
	input wire logic miso_out,
	input wire logic miso_oe_out,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);
	logic sclk_d_ff; // Clock pin one cycle ago
	logic [3:0] since_fall_ff; // Cycles since the clock pin fell
	// Raw pin delay for the edge finder
	always_ff @(posedge clk_sys_in) begin
		sclk_d_ff <= sclk_in;
	end
	// Age of the last fall; saturates so idle gaps never wrap round
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			since_fall_ff <= 4'hF;
		end else if (sclk_d_ff && !sclk_in) begin
			since_fall_ff <= 4'h0;
		end else if (since_fall_ff != 4'hF) begin
			since_fall_ff <= since_fall_ff + 4'h1;
		end
	end
	sequence s_setup;
		psel_in && !penable_in;
	endsequence
	sequence s_access;
		psel_in && penable_in;
	endsequence
	property p_wait_state;
		s_setup ##1 s_access |=> pready_out;
	endproperty
	a_wait_state: assert property (p_wait_state) else $error("bus answer missing after one wait state");
	property p_no_early;
		s_setup ##1 s_access |-> !pready_out;
	endproperty
	a_no_early: assert property (p_no_early) else $error("bus answer came without the wait state");
	property p_pulse;
		pready_out |=> !pready_out;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready stood longer than one cycle");
	property p_err_only;
		pslverr_out |-> pready_out && psel_in && penable_in;
	endproperty
	a_err_only: assert property (p_err_only) else $error("error flag outside an answer");
	property p_unmapped;
		pready_out && !(paddr_in inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}) |-> pslverr_out && prdata_out == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped address not refused");
	property p_mapped;
		pready_out && (paddr_in inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}) |-> !pslverr_out;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped address refused");
	property p_desel_off;
		sel_n_in [*6] |-> !miso_oe_out;
	endproperty
	a_desel_off: assert property (p_desel_off) else $error("output driven while deselected");
	property p_pause_off;
		(!sel_n_in && !pause_n_in) [*6] |-> !miso_oe_out;
	endproperty
	a_pause_off: assert property (p_pause_off) else $error("output driven while paused");
	property p_shift_fall;
		miso_oe_out && $past(miso_oe_out) && $changed(miso_out) |-> since_fall_ff inside {[1:5]};
	endproperty
	a_shift_fall: assert property (p_shift_fall) else $error("output bit moved away from a falling edge");
endmodule
bind sff_front sff_front_monitor mon_u (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .sclk_in(sclk_in),
	.sel_n_in(sel_n_in), .pause_n_in(pause_n_in), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
	.psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
	.pready_out(pready_out), .pslverr_out(pslverr_out));

// ---- verification/sff_spi_master.sv ----
`timescale 1ns/1ns
// Behavioural controller on the far side of the serial pins
module sff_spi_master (
	input wire logic clk_sys_in,
	input wire logic miso_in,
	input wire logic miso_oe_in,
	output logic sclk_out,
	output logic sel_n_out,
	output logic mosi_out,
	output logic pause_n_out
);
	logic cpol = 1'b0; // Idle clock level, low or high both served
	// Quiet pins at power-up
	initial begin
		sclk_out = 1'b0;
		sel_n_out = 1'b1;
		mosi_out = 1'b0;
		pause_n_out = 1'b1;
	end
	// Half a link clock period, 80 ns in all
	task automatic half();
		repeat (4) @(posedge clk_sys_in);
	endtask
	// Falling select edge comes before any instruction
	task automatic select();
		@(posedge clk_sys_in);
		sclk_out <= cpol;
		half();
		sel_n_out <= 1'b0;
		half();
	endtask
	// Clock back to idle, data line shows no stale bit
	task automatic deselect();
		half();
		sel_n_out <= 1'b1;
		sclk_out <= cpol;
		mosi_out <= ~mosi_out;
		half();
	endtask
	// MSB first, set while clock low, held across the rise
	task automatic bits(input logic [7:0] v, input int n, output logic [7:0] rx);
		for (int i = n - 1; i >= 0; i--) begin
			sclk_out <= 1'b0;
			mosi_out <= v[i];
			half();
			sclk_out <= 1'b1;
			half();
			// Undriven line reads as garbage, never as a good bit
			rx = {rx[6:0], (miso_oe_in === 1'b1) ? miso_in : ~rx[0]};
		end
	endtask
	// Pause only while selected; clock and data wiggle meanwhile
	task automatic hold_for(input int n);
		pause_n_out <= 1'b0;
		repeat (n) begin
			half();
			sclk_out <= ~sclk_out;
			mosi_out <= ~mosi_out;
		end
		half();
		pause_n_out <= 1'b1;
		half();
	endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
// Self-checking bench for the serial front end
module tb_top;
	logic clk_sys = 1'b0; // System clock
	logic reset = 1'b1; // Synchronous reset
	logic wp_n = 1'b1; // Write protect pin
	logic psel = 1'b0; // Bus request
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sclk;
	logic sel_n;
	logic mosi;
	logic pause_n;
	logic miso;
	logic miso_oe;
	int fails = 0; // Mismatches
	int tests_run = 0; // Compares made
	int cycles = 0; // Hang guard
	logic [7:0] rx; // Byte back from the link
	logic [31:0] rd; // Word back from the bus
	logic err; // Bus error flag
	sff_front dut_u (.clk_sys_in(clk_sys), .reset_in(reset), .ce_in(1'b1), .sclk_in(sclk), .sel_n_in(sel_n),
		.mosi_in(mosi), .pause_n_in(pause_n), .wp_n_in(wp_n), .miso_out(miso), .miso_oe_out(miso_oe),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));
	sff_spi_master master_u (.clk_sys_in(clk_sys), .miso_in(miso), .miso_oe_in(miso_oe), .sclk_out(sclk),
		.sel_n_out(sel_n), .mosi_out(mosi), .pause_n_out(pause_n));
	// 50 MHz system clock
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	// Whole run needs a few thousand cycles; this ceiling means a hang
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("Compares %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One transfer, held until ready; only the bench timeout ends a wait
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Read, then compare the masked bits
	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd & m, exp);
	endtask
	function automatic logic [31:0] fb(input int p);
		return 32'h0000_0001 << p;
	endfunction
	// Expected receive word: valid, kind, address, byte
	function automatic logic [31:0] word(input logic [1:0] k, input logic [18:0] a, input logic [7:0] b);
		return {1'b1, 2'b00, k, a, b};
	endfunction
	task automatic xb(input logic [7:0] v);
		master_u.bits(v, 8, rx);
	endtask
	task automatic hdr(input logic [7:0] op, input logic [23:0] a);
		master_u.select();
		xb(op);
		xb(a[23:16]);
		xb(a[15:8]);
		xb(a[7:0]);
	endtask
	// Select already low as reset lifts: no edge, nothing taken
	task automatic t_unarmed();
		@(posedge clk_sys);
		master_u.select();
		reset <= 1'b0;
		xb(sff_pkg::PAGE_WRITE_CMD);
		xb(8'h00);
		xb(8'h01);
		xb(8'h02);
		xb(8'h77);
		master_u.deselect();
		rdm(sff_pkg::OFS_RX, 32'h8000_0000, 32'h0);
		rdm(sff_pkg::OFS_STAT, fb(sff_pkg::ST_ARMED), 32'h0);
	endtask
	// Reset values and an unmapped place
	task automatic t_regs();
		rdm(sff_pkg::OFS_CTRL, 32'h1, 32'h0);
		rdm(sff_pkg::OFS_GUARD, 32'h7, 32'h0);
		rdm(sff_pkg::OFS_TX, 32'hFF, 32'hFF);
		rdm(sff_pkg::OFS_STAT, fb(sff_pkg::ST_STANDBY), fb(sff_pkg::ST_STANDBY));
		apb(1'b1, 8'h14, 32'h1);
		chk({31'h0, err}, 32'h1);
	endtask
	// Page write with a pause mid-byte, in-page wrap, one word too many
	task automatic t_page();
		hdr(sff_pkg::PAGE_WRITE_CMD, 24'hF712FE);
		rdm(sff_pkg::OFS_STAT, fb(sff_pkg::ST_SEL) | fb(sff_pkg::ST_STANDBY), fb(sff_pkg::ST_SEL));
		xb(8'h11);
		master_u.bits(8'h02, 4, rx);
		master_u.hold_for(2);
		master_u.bits(8'h22, 4, rx);
		xb(8'h33);
		xb(8'h44);
		master_u.deselect();
		rdm(sff_pkg::OFS_RX, 32'hFFFF_FFFF, word(sff_pkg::KIND_DATA, 19'h712FE, 8'h11));
		rdm(sff_pkg::OFS_RX, 32'hFFFF_FFFF, word(sff_pkg::KIND_DATA, 19'h712FF, 8'h22));
		rdm(sff_pkg::OFS_RX, 32'hFFFF_FFFF, word(sff_pkg::KIND_DATA, 19'h71200, 8'h33));
		rdm(sff_pkg::OFS_RX, 32'h8000_0000, 32'h0);
		rdm(sff_pkg::OFS_STAT, fb(sff_pkg::ST_OVR), fb(sff_pkg::ST_OVR));
		apb(1'b1, sff_pkg::OFS_STAT, fb(sff_pkg::ST_OVR));
		rdm(sff_pkg::OFS_STAT, fb(sff_pkg::ST_OVR), 32'h0);
	endtask
	// Both wipes, then a frozen guard refusing its own area
	task automatic t_wipe();
		hdr(sff_pkg::SECTOR_WIPE_CMD, 24'h030000);
		master_u.deselect();
		master_u.select();
		xb(sff_pkg::CHIP_WIPE_CMD);
		master_u.deselect();
		rdm(sff_pkg::OFS_RX, 32'hFFFF_FF00, word(sff_pkg::KIND_SECTOR, 19'h30000, 8'h00));
		rdm(sff_pkg::OFS_RX, 32'h9800_0000, 32'h9800_0000);
		apb(1'b1, sff_pkg::OFS_GUARD, 32'h1);
		wp_n <= 1'b0;
		apb(1'b1, sff_pkg::OFS_GUARD, 32'h4);
		rdm(sff_pkg::OFS_GUARD, 32'h7, 32'h1);
		hdr(sff_pkg::SECTOR_WIPE_CMD, 24'h070000);
		master_u.deselect();
		master_u.select();
		xb(sff_pkg::CHIP_WIPE_CMD);
		master_u.deselect();
		rdm(sff_pkg::OFS_RX, 32'h8000_0000, 32'h0);
		rdm(sff_pkg::OFS_STAT, fb(sff_pkg::ST_REF), fb(sff_pkg::ST_REF));
		apb(1'b1, sff_pkg::OFS_STAT, fb(sff_pkg::ST_REF));
		hdr(sff_pkg::SECTOR_WIPE_CMD, 24'h060000);
		master_u.deselect();
		rdm(sff_pkg::OFS_RX, 32'hFFFF_FF00, word(sff_pkg::KIND_SECTOR, 19'h60000, 8'h00));
		wp_n <= 1'b1;
		apb(1'b1, sff_pkg::OFS_GUARD, 32'h0);
	endtask
	// Busy keeps the part active; status read with the clock idling high
	task automatic t_status();
		master_u.pause_n_out <= 1'b0;
		apb(1'b1, sff_pkg::OFS_CTRL, 32'h1);
		rdm(sff_pkg::OFS_STAT, fb(sff_pkg::ST_STANDBY) | fb(sff_pkg::ST_PAUSE), 32'h0);
		master_u.pause_n_out <= 1'b1;
		master_u.cpol = 1'b1;
		master_u.select();
		xb(sff_pkg::STAT_CMD);
		xb(8'hFF);
		chk({24'h0, rx}, 32'h03);
		master_u.deselect();
		master_u.cpol = 1'b0;
		apb(1'b1, sff_pkg::OFS_CTRL, 32'h0);
		rdm(sff_pkg::OFS_STAT, fb(sff_pkg::ST_STANDBY), fb(sff_pkg::ST_STANDBY));
	endtask
	// Asleep: a page write is ignored, only the wake command answers
	task automatic t_sleep();
		master_u.select();
		xb(sff_pkg::SLEEP_CMD);
		master_u.deselect();
		rdm(sff_pkg::OFS_STAT, fb(sff_pkg::ST_SLEEP), fb(sff_pkg::ST_SLEEP));
		hdr(sff_pkg::PAGE_WRITE_CMD, 24'h000000);
		xb(8'h55);
		master_u.deselect();
		rdm(sff_pkg::OFS_RX, 32'h8000_0000, 32'h0);
		master_u.select();
		xb(sff_pkg::WAKE_CMD);
		xb(8'h00);
		chk({24'h0, rx}, {24'h0, sff_pkg::SIG_BYTE});
		master_u.deselect();
		rdm(sff_pkg::OFS_STAT, fb(sff_pkg::ST_SLEEP), 32'h0);
	endtask
	// Main sequence
	initial begin
		t_unarmed();
		t_regs();
		t_page();
		t_wipe();
		t_status();
		t_sleep();
		report_and_stop();
	end
endmodule
